/* File: rtl/acl_pkg.sv */
// Purpose: shared constants and types for the codec link control registers
// Assumes: word-indexed register map on the peripheral bus, 32-bit data
// Notes: indices are word numbers; byte address is four times the index
package acl_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [8:0] ACL_IDX_MAIN_CTRL = 9'h000;
  localparam logic [8:0] ACL_IDX_IRQ_CTRL = 9'h008;

  // ----------------------------------------------------------------
  // main control fields
  // ----------------------------------------------------------------
  localparam int ACL_MC_COLD_BIT = 32'h0;
  localparam int ACL_MC_WARM_BIT = 32'h1;
  localparam int ACL_MC_EN_BIT = 32'h7;
  localparam int ACL_MC_PE_LSB = 32'h12;
  localparam int ACL_NUM_FIFO = 32'h5;
  localparam logic ACL_MC_COLD_RST_VAL = 1'h1;
  localparam logic ACL_MC_WARM_RST_VAL = 1'h0;
  localparam logic ACL_MC_EN_RST_VAL = 1'h0;

  // ----------------------------------------------------------------
  // interrupt control fields, port order shared by enable and identify
  // ----------------------------------------------------------------
  localparam int ACL_IC_ID_LSB = 32'h0;
  localparam int ACL_IC_EN_LSB = 32'h8;
  localparam int ACL_NUM_PORT = 32'h6;
  localparam int ACL_P_CMD = 32'h0;
  localparam int ACL_P_PLAY = 32'h1;
  localparam int ACL_P_REC = 32'h2;
  localparam int ACL_P_MOUT = 32'h3;
  localparam int ACL_P_MIN = 32'h4;
  localparam int ACL_P_MIC = 32'h5;

  // ports whose interrupt enable waits for an output frame
  localparam logic [5:0] ACL_WR_SIDE_MASK = 6'h0b;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic req;
    logic we;
    logic [8:0] idx;
    logic [31:0] wdata;
  } acl_bus_req_t;

  typedef struct packed {
    logic t_ready;
    logic [31:0] rdata;
  } acl_bus_rsp_t;

  // raw source conditions, one bit each
  typedef struct packed {
    logic mic_half_full;
    logic min_half_full;
    logic mout_half_empty;
    logic rec_half_full;
    logic play_half_empty;
    logic cmd_rd_full;
    logic cmd_wr_empty;
  } acl_src_t;

endpackage

/* File: rtl/acl_evt_gate.sv */
// Purpose: turns one source condition into a gated one-cycle event
// Assumes: condition is synchronous to mclk, level or pulse
// Notes: a held level yields only one event at its rising edge
`timescale 1ns/100ps
`default_nettype none
module acl_evt_gate (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // condition and gate
  input wire logic cond,
  input wire logic enable,
  // gated event
  output logic evt
);

  // ----------------------------------------------------------------
  // edge detect
  // ----------------------------------------------------------------
  logic prev_r;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prev_r <= 1'h0;
    end else begin
      prev_r <= cond;
    end
  end

  assign evt = cond & ~prev_r & enable;

endmodule
`default_nettype wire

/* File: rtl/acl_ctrl_regs.sv */
// Purpose: main control and interrupt control registers of the link
// Assumes: peripheral bus strobes one-cycle requests; answer next cycle
// Notes: port and interrupt enable fields carry no reset value
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - master enable bit 7 low disables all link controller functions; bits 1:0 still drive the codec resets
// - bits 22:18 enable the five fifo stream ports individually
// - bit 1 set holds the codec link in warm reset
// - bit 0 set holds the external codec in cold reset
// - bus reset sets the cold reset bit to one
// - reset state persists until software clears its bit
// - main control register is readable and writable over the bus
// - port enable field has no reset value
// - fifo half empty or half full events raise write or read line
// - interrupt control bits 13:8 enable each of the six ports
// - cleared enable suppresses that port's interrupt
// - interrupt enable bits have no reset value
// - interrupt control register accessible any time without waits
// - write-side enable change applies after the next output frame
// - read-side enable change applies immediately
// - bits 5:0 identify which ports are in interrupt state
// - each interrupt line pulses high for one clock cycle
// - port order cmd, play, rec, mout, min, mic; line split by side
module acl_ctrl_regs
  import acl_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // peripheral bus
  input wire acl_bus_req_t pb_req,
  output acl_bus_rsp_t pb_rsp,
  // link timing
  input wire logic out_frame_end,
  // event sources
  input wire acl_src_t src,
  // control outputs
  output logic link_enable,
  output logic [ACL_NUM_FIFO-1:0] port_enable,
  output logic codec_warm_rst,
  output logic codec_cold_rst,
  // interrupt lines
  output logic int_w,
  output logic int_r
);

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic mc_wr, mc_rd, ic_wr, ic_rd;

  assign mc_wr = pb_req.req & pb_req.we & (pb_req.idx == ACL_IDX_MAIN_CTRL);
  assign mc_rd = pb_req.req & ~pb_req.we & (pb_req.idx == ACL_IDX_MAIN_CTRL);
  assign ic_wr = pb_req.req & pb_req.we & (pb_req.idx == ACL_IDX_IRQ_CTRL);
  assign ic_rd = pb_req.req & ~pb_req.we & (pb_req.idx == ACL_IDX_IRQ_CTRL);

  // ----------------------------------------------------------------
  // main control
  // ----------------------------------------------------------------
  logic main_en_r, warm_r, cold_r;
  logic [ACL_NUM_FIFO-1:0] port_en_r;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      main_en_r <= ACL_MC_EN_RST_VAL;
      warm_r <= ACL_MC_WARM_RST_VAL;
      cold_r <= ACL_MC_COLD_RST_VAL;
    end else if (mc_wr) begin
      main_en_r <= pb_req.wdata[ACL_MC_EN_BIT];
      warm_r <= pb_req.wdata[ACL_MC_WARM_BIT];
      cold_r <= pb_req.wdata[ACL_MC_COLD_BIT];
    end
  end

  // no reset on the port enable field
  always_ff @(posedge mclk) begin
    if (mc_wr) begin
      port_en_r <= pb_req.wdata[ACL_MC_PE_LSB +: ACL_NUM_FIFO];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      link_enable <= 1'h0;
      port_enable <= '0;
      codec_warm_rst <= 1'h0;
      codec_cold_rst <= 1'h1;
    end else begin
      link_enable <= main_en_r;
      port_enable <= main_en_r ? port_en_r : '0;
      codec_warm_rst <= warm_r;
      codec_cold_rst <= cold_r;
    end
  end

  // ----------------------------------------------------------------
  // interrupt enables
  // ----------------------------------------------------------------
  logic [ACL_NUM_PORT-1:0] ien_r, wr_ien_r, eff_ien;

  always_ff @(posedge mclk) begin
    if (ic_wr) begin
      ien_r <= pb_req.wdata[ACL_IC_EN_LSB +: ACL_NUM_PORT];
    end
  end

  // write-side copy reloads only at an output frame end
  // held off by reset so no write-side event fires before the first frame
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wr_ien_r <= '0;
    end else if (out_frame_end) begin
      wr_ien_r <= ien_r;
    end
  end

  assign eff_ien = (wr_ien_r & ACL_WR_SIDE_MASK) |
                   (ien_r & ~ACL_WR_SIDE_MASK);

  // ----------------------------------------------------------------
  // event gating
  // ----------------------------------------------------------------
  localparam int NSRC = $bits(acl_src_t);
  logic [NSRC-1:0] src_v, src_en, hit;

  assign src_v = src;
  // cmd read full uses the immediate enable of port 0
  assign src_en = {eff_ien[ACL_P_MIC], eff_ien[ACL_P_MIN],
                   eff_ien[ACL_P_MOUT], eff_ien[ACL_P_REC],
                   eff_ien[ACL_P_PLAY], ien_r[ACL_P_CMD],
                   eff_ien[ACL_P_CMD]};

  genvar g;
  generate
    for (g = 0; g < NSRC; g++) begin : g_src
      acl_evt_gate u_gate (
        .mclk(mclk),
        .rst(rst),
        .cond(src_v[g]),
        .enable(src_en[g] & main_en_r),
        .evt(hit[g])
      );
    end
  endgenerate

  logic wr_any, rd_any;
  logic [ACL_NUM_PORT-1:0] port_hit;

  assign wr_any = hit[0] | hit[2] | hit[4];
  assign rd_any = hit[1] | hit[3] | hit[5] | hit[6];
  assign port_hit = {hit[6], hit[5], hit[4], hit[3], hit[2],
                     hit[0] | hit[1]};

  // ----------------------------------------------------------------
  // interrupt lines
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      int_w <= 1'h0;
      int_r <= 1'h0;
    end else begin
      int_w <= wr_any;
      int_r <= rd_any;
    end
  end

  // ----------------------------------------------------------------
  // identify bits, sticky, cleared by a read, set wins
  // ----------------------------------------------------------------
  logic [ACL_NUM_PORT-1:0] id_r;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      id_r <= '0;
    end else begin
      id_r <= (ic_rd ? '0 : id_r) | port_hit;
    end
  end

  // ----------------------------------------------------------------
  // bus answer
  // ----------------------------------------------------------------
  logic [31:0] rd_word;

  always_comb begin
    rd_word = '0;
    if (mc_rd) begin
      rd_word[ACL_MC_EN_BIT] = main_en_r;
      rd_word[ACL_MC_WARM_BIT] = warm_r;
      rd_word[ACL_MC_COLD_BIT] = cold_r;
      rd_word[ACL_MC_PE_LSB +: ACL_NUM_FIFO] = port_en_r;
    end else if (ic_rd) begin
      rd_word[ACL_IC_EN_LSB +: ACL_NUM_PORT] = ien_r;
      rd_word[ACL_IC_ID_LSB +: ACL_NUM_PORT] = id_r;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pb_rsp <= '0;
    end else begin
      pb_rsp.t_ready <= pb_req.req;
      pb_rsp.rdata <= rd_word;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  property p_cold_after_reset;
    $past(rst) |-> codec_cold_rst;
  endproperty
  a_cold_after_reset: assert property (p_cold_after_reset)
    else $error("cold reset not set after bus reset");

  property p_cold_write;
    mc_wr |=> ##1 (codec_cold_rst == $past(pb_req.wdata[ACL_MC_COLD_BIT], 2));
  endproperty
  a_cold_write: assert property (p_cold_write)
    else $error("cold reset output does not follow its bit");

  property p_warm_hold;
    (mc_wr && pb_req.wdata[ACL_MC_WARM_BIT]) ##1 !mc_wr |=> codec_warm_rst;
  endproperty
  a_warm_hold: assert property (p_warm_hold)
    else $error("warm reset not held while bit set");

  property p_master_off;
    (!main_en_r ##1 !main_en_r) |-> (!int_w && !int_r && port_enable == '0);
  endproperty
  a_master_off: assert property (p_master_off)
    else $error("activity while master enable is low");

  property p_port_en_write;
    (mc_wr && pb_req.wdata[ACL_MC_EN_BIT]) |=> ##1
      (port_enable == $past(pb_req.wdata[ACL_MC_PE_LSB +: ACL_NUM_FIFO], 2));
  endproperty
  a_port_en_write: assert property (p_port_en_write)
    else $error("port enables do not follow write");

  property p_int_w_cause;
    int_w |-> $past(wr_any);
  endproperty
  a_int_w_cause: assert property (p_int_w_cause)
    else $error("write line pulse without a write-side event");

  property p_int_r_cause;
    rd_any |=> int_r;
  endproperty
  a_int_r_cause: assert property (p_int_r_cause)
    else $error("read-side event did not pulse read line");

  property p_wr_side_wait;
    !out_frame_end |=> $stable(wr_ien_r);
  endproperty
  a_wr_side_wait: assert property (p_wr_side_wait)
    else $error("write-side enable changed without a frame end");

  property p_rd_side_now;
    ic_wr |=> (eff_ien[ACL_P_REC] == $past(pb_req.wdata[ACL_IC_EN_LSB +
      ACL_P_REC]));
  endproperty
  a_rd_side_now: assert property (p_rd_side_now)
    else $error("read-side enable not applied at once");

  property p_id_set;
    (port_hit[ACL_P_PLAY] && !ic_rd) |=> id_r[ACL_P_PLAY];
  endproperty
  a_id_set: assert property (p_id_set)
    else $error("identify bit not set by its event");

  property p_unused_zero;
    ic_rd |=> (pb_rsp.t_ready && pb_rsp.rdata[31:14] == '0 &&
      pb_rsp.rdata[7:6] == '0);
  endproperty
  a_unused_zero: assert property (p_unused_zero)
    else $error("unused interrupt control bits not zero");

  property p_mc_readback;
    mc_rd |=> (pb_rsp.t_ready &&
      pb_rsp.rdata[ACL_MC_EN_BIT] == $past(main_en_r));
  endproperty
  a_mc_readback: assert property (p_mc_readback)
    else $error("main control readback wrong");

  property p_warm_write;
    mc_wr |=> ##1 (codec_warm_rst == $past(pb_req.wdata[ACL_MC_WARM_BIT], 2));
  endproperty
  a_warm_write: assert property (p_warm_write)
    else $error("warm reset output does not follow its bit");

  property p_reset_hold;
    !mc_wr |=> ##1 ($stable(codec_warm_rst) && $stable(codec_cold_rst));
  endproperty
  a_reset_hold: assert property (p_reset_hold)
    else $error("codec reset output changed without a write");

  property p_link_en_write;
    mc_wr |=> ##1 (link_enable == $past(pb_req.wdata[ACL_MC_EN_BIT], 2));
  endproperty
  a_link_en_write: assert property (p_link_en_write)
    else $error("link enable does not follow master enable bit");

  property p_ready_next;
    pb_req.req |=> pb_rsp.t_ready;
  endproperty
  a_ready_next: assert property (p_ready_next)
    else $error("bus request not answered in the next cycle");

  property p_ien_write;
    ic_wr |=> (ien_r == $past(pb_req.wdata[ACL_IC_EN_LSB +: ACL_NUM_PORT]));
  endproperty
  a_ien_write: assert property (p_ien_write)
    else $error("interrupt enables do not follow write");

  property p_wr_side_load;
    out_frame_end |=> (wr_ien_r == $past(ien_r));
  endproperty
  a_wr_side_load: assert property (p_wr_side_load)
    else $error("write-side enables not loaded at frame end");

  property p_gated_off;
    (eff_ien == '0 && !ien_r[ACL_P_CMD]) |=> (!int_w && !int_r);
  endproperty
  a_gated_off: assert property (p_gated_off)
    else $error("interrupt pulse with all enables cleared");

  property p_no_pulse_held;
    $stable(src) |=> (!int_w && !int_r);
  endproperty
  a_no_pulse_held: assert property (p_no_pulse_held)
    else $error("interrupt line pulsed without a new event");

  property p_id_clear;
    (ic_rd && port_hit == '0) |=> (id_r == '0);
  endproperty
  a_id_clear: assert property (p_id_clear)
    else $error("identify bits not cleared by a read");

endmodule
`default_nettype wire

/* File: testbench/acl_sw_master.sv */
// Purpose: software side of the peripheral bus for the control registers
// Assumes: one-cycle request strobe, answer one cycle after the take edge
// Notes: idle request fields show an inverted pattern, never stale values
`timescale 1ns/100ps
`default_nettype none
module acl_sw_master
  import acl_pkg::*;
(
  // clock
  input wire logic mclk,
  // peripheral bus
  output var acl_bus_req_t pb_req,
  input wire acl_bus_rsp_t pb_rsp
);
  initial pb_req = '0;
  // one word access; ok only if answered with no wait state
  task automatic xfer(input logic we, input logic [8:0] idx,
    input logic [31:0] wd, output logic [31:0] rd, output logic ok);
    int n;
    n = 0;
    @(posedge mclk);
    pb_req <= '{1'b1, we, idx, wd};
    @(posedge mclk);
    pb_req <= '{1'b0, ~we, ~idx, ~wd};
    @(posedge mclk);
    while (pb_rsp.t_ready !== 1'b1 && n < 3) begin
      @(posedge mclk);
      n++;
    end
    ok = (n == 0) && (pb_rsp.t_ready === 1'b1);
    rd = pb_rsp.rdata;
  endtask
endmodule
`default_nettype wire

/* File: testbench/tb_top.sv */
// Purpose: self-checking bench for the link control registers
// Assumes: outputs settle within three edges of a bus answer
// Notes: interrupt events are single rising edges of one source bit
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import acl_pkg::*;
();
  logic mclk, rst, ofe, ok, le, wr, cr, iw, ir;
  logic [ACL_NUM_FIFO-1:0] pe;
  logic [31:0] rd;
  acl_bus_req_t pb_req;
  acl_bus_rsp_t pb_rsp;
  acl_src_t src;
  int failures, compares;
  logic [31:0] mc_wd [4] = '{32'h007c_0083, 32'h0054_0080,
    32'h0028_0002, 32'h0000_0001};
  logic [7:0] mc_exp [4] = '{8'hff, 8'hd4, 8'h02, 8'h01};

  acl_ctrl_regs i_acl_ctrl_regs (.mclk(mclk), .rst(rst),
    .pb_req(pb_req), .pb_rsp(pb_rsp), .out_frame_end(ofe), .src(src),
    .link_enable(le), .port_enable(pe), .codec_warm_rst(wr),
    .codec_cold_rst(cr), .int_w(iw), .int_r(ir));
  acl_sw_master i_acl_sw_master (.mclk(mclk), .pb_req(pb_req),
    .pb_rsp(pb_rsp));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic acc(input logic we, input logic [8:0] idx,
    input logic [31:0] wd);
    i_acl_sw_master.xfer(we, idx, wd, rd, ok);
    chk("bus answer", 32'(ok), 32'h1);
  endtask

  task automatic frame();
    @(posedge mclk);
    ofe <= 1'b1;
    @(posedge mclk);
    ofe <= 1'b0;
  endtask

  task automatic evt(input int s, input logic ew, er);
    @(posedge mclk);
    src <= acl_src_t'(7'h01 << s);
    repeat (2) @(posedge mclk);
    chk("int_w", 32'(iw), 32'(ew));
    chk("int_r", 32'(ir), 32'(er));
    @(posedge mclk);
    chk("int pulse end", 32'({iw, ir}), 32'h0);
    src <= '0;
  endtask

  task automatic tally_and_finish();
    if (failures == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (6000) @(posedge mclk);
    failures++;
    tally_and_finish();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    ofe = 1'b0;
    src = '0;
    repeat (4) @(posedge mclk);
    chk("reset outputs", 32'({le, wr, cr, iw, ir}), 32'h04);
    rst <= 1'b0;
    acc(1'b0, ACL_IDX_MAIN_CTRL, '0);
    chk("main after reset", rd & 32'h83, 32'h01);
    for (int i = 0; i < 4; i++) begin
      acc(1'b1, ACL_IDX_MAIN_CTRL, mc_wd[i]);
      acc(1'b0, ACL_IDX_MAIN_CTRL, '0);
      chk("main readback", rd & 32'h007c_0083, mc_wd[i]);
      chk("outs", 32'({le, pe, wr, cr}), 32'(mc_exp[i]));
    end
    repeat (20) @(posedge mclk);
    chk("cold held", 32'(cr), 32'h1);
    acc(1'b1, ACL_IDX_MAIN_CTRL, 32'h007c_0080);
    acc(1'b1, ACL_IDX_IRQ_CTRL, 32'h0000_3f00);
    frame();
    for (int s = 0; s < 7; s++) begin
      evt(s, s == 0 || s == 2 || s == 4, !(s == 0 || s == 2 || s == 4));
      acc(1'b0, ACL_IDX_IRQ_CTRL, '0);
      chk("id", rd, 32'h3f00 | 32'(1 << (s - (s > 0))));
    end
    acc(1'b1, ACL_IDX_IRQ_CTRL, 32'h0);
    evt(3, 1'b0, 1'b0);
    evt(2, 1'b1, 1'b0);
    frame();
    evt(2, 1'b0, 1'b0);
    evt(0, 1'b0, 1'b0);
    acc(1'b0, ACL_IDX_IRQ_CTRL, '0);
    chk("identify gated", rd, 32'h2);
    acc(1'b1, ACL_IDX_IRQ_CTRL, 32'h0000_3f00);
    frame();
    acc(1'b1, ACL_IDX_MAIN_CTRL, 32'h007c_0000);
    evt(3, 1'b0, 1'b0);
    evt(4, 1'b0, 1'b0);
    chk("ports off", 32'(pe), 32'h0);
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    chk("cold in reset", 32'({le, cr}), 32'h1);
    rst <= 1'b0;
    acc(1'b0, ACL_IDX_MAIN_CTRL, '0);
    chk("port en kept", rd & 32'h007c_0083, 32'h007c_0001);
    acc(1'b0, ACL_IDX_IRQ_CTRL, '0);
    chk("irq en kept", rd & 32'h3f00, 32'h3f00);
    tally_and_finish();
  end
endmodule
`default_nettype wire
